// file: src/pwr_seq_pkg.sv
// Constants, field layouts and types shared by the mode and reset sequencer
package pwr_seq_pkg;

  // Register word addresses (byte addresses on the Wishbone bus)
  localparam logic [7:0] addr_osc_control = 8'h00;
  localparam logic [7:0] addr_status = 8'h04;
  localparam logic [7:0] addr_config = 8'h08;
  localparam logic [7:0] addr_mode = 8'h0c;

  // Control register field positions
  localparam int high_osc_select_bit = 0;
  localparam int high_osc_stop_bit = 1;
  localparam int power_mode_lo = 2;
  localparam int power_mode_hi = 3;
  localparam int low_clk_to_timer_zero_bit = 4;

  // Status register field positions
  localparam int power_down_bit = 3;
  localparam int timeout_bit = 4;

  // Config register field positions
  localparam int pwrup_sel_lo = 0;
  localparam int pwrup_sel_hi = 2;
  localparam int startup_fast_bit = 3;
  localparam int crystal_mode_bit = 4;
  localparam int timer_zero_src_bit = 5;

  // Power mode field encodings
  localparam logic [1:0] pm_run = 2'h0;
  localparam logic [1:0] pm_halt = 2'h1;
  localparam logic [1:0] pm_standby = 2'h2;

  localparam logic [7:0] osc_control_reset = 8'h01;
  localparam logic [7:0] config_reset = 8'h0b;
  localparam logic [11:0] irq_vector = 12'h008;

  // Settle counts in oscillator cycles
  localparam logic [9:0] halt_settle_xtal = 10'h200;
  localparam logic [9:0] halt_settle_rc = 10'h010;
  localparam logic [9:0] ost_short = 10'h001;
  localparam logic [9:0] ost_long = 10'h010;

  // Power-up delays in microseconds
  localparam int pwrup_us_0 = 140;
  localparam int pwrup_us_1 = 4500;
  localparam int pwrup_us_2 = 18000;
  localparam int pwrup_us_3 = 72000;
  localparam int pwrup_us_4 = 288000;
  localparam int clk_mhz = 250;

  typedef enum logic [5:0] {
    st_reset  = 6'b000001,
    st_pwrup  = 6'b000010,
    st_ost    = 6'b000100,
    st_run    = 6'b001000,
    st_standby = 6'b010000,
    st_halt   = 6'b100000
  } seq_state_t;

  typedef enum logic [6:0] {
    ps_reset   = 7'b0000001,
    ps_normal  = 7'b0000010,
    ps_slow    = 7'b0000100,
    ps_standby = 7'b0001000,
    ps_halt    = 7'b0010000,
    ps_settle  = 7'b0100000,
    ps_pwrup   = 7'b1000000
  } mode_code_t;

  // Wake sources grouped together
  typedef struct packed {
    logic timer_zero_ovf;
    logic timer_one_unf;
    logic timer_three_unf;
    logic watchdog_timeout;
    logic port_change;
    logic ext_irq_zero;
    logic ext_irq_one;
    logic low_voltage_detect;
    logic comparator_change;
  } wake_events_t;

  // Reset sources grouped together
  typedef struct packed {
    logic power_on;
    logic low_voltage_reset;
    logic watchdog_reset;
  } reset_events_t;

  // Clock and gate outputs
  typedef struct packed {
    logic fast_osc_en;
    logic slow_osc_en;
    logic sys_clk_fast;
    logic cpu_run;
    logic periph_en;
    logic timers_en;
    logic timer_zero_slow_clk;
  } clock_ctrl_t;

endpackage

// file: src/pin_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/10ps
module pin_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic pin_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change counts only once the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_out <= 1'b1;
    end else if (s2_reg == s3_reg) begin
      pin_out <= s3_reg;
    end
  end
endmodule

// file: src/cycle_timer.sv
// Loadable down counter that counts enable pulses and flags completion
`timescale 1ns/10ps
module cycle_timer #(
  parameter int width = 27
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [width-1:0] load_value,
  input wire logic tick,
  output logic done
);
  logic [width-1:0] count_reg;
  logic busy_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
    end else if (load) begin
      count_reg <= load_value;
      busy_reg <= 1'b1;
    end else if (busy_reg && tick) begin
      if (count_reg <= width'(1)) begin
        busy_reg <= 1'b0;
        count_reg <= '0;
      end else begin
        count_reg <= count_reg - width'(1);
      end
    end
  end

  assign done = busy_reg && tick && (count_reg <= width'(1));
endmodule

// file: src/power_mode_reset_sequencer.sv
// Operating mode and reset sequencer with a Wishbone register port
//
// What this block does
// - After reset the startup setting picks normal or slow mode.
// - Select bit 0 runs on slow oscillator, 1 on fast oscillator.
// - Normal mode runs from fast clock; slow oscillator keeps running.
// - Slow mode leaves fast oscillator on; stop bit turns it off.
// - Writing 10b to mode field bits [3:2] enters standby.
// - Standby stops execution; slow oscillator and enabled timers keep running.
// - Standby wakes on timer, watchdog, port, external, low-voltage or comparator event.
// - After wake the select bit picks normal or slow mode.
// - Halt is entered by sleep instruction or writing 01b to mode field.
// - Entering halt clears power-down, sets timeout, clears watchdog.
// - Halt stops both oscillators, execution and all peripherals.
// - Halt wakes only on watchdog, port change or external interrupts.
// - Halt wake waits 512 cycles with crystal mode, otherwise 16.
// - Standby wake needs no settle delay.
// - Wake with interrupts enabled vectors to 0x008, else continues.
// - Stop bit and halt entry may be written together.
// - Slow clock feeds timer zero when both enabling bits and the select bit are 1.
// - Reset on power-on, low voltage, reset pin low, watchdog reset.
// - Reset loads defined initial values; unknown ones keep contents.
// - Timeout and power-down flags follow the reset cause table.
// - After reset a selectable power-up delay runs, any oscillator.
// - Then a start-up count of 1 or 16 oscillator cycles runs.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module power_mode_reset_sequencer #(
  parameter int fast_div = 4,
  parameter int slow_div = 7629,
  parameter int us_div = 250
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_reset_n,
  input wire pwr_seq_pkg::reset_events_t reset_events,
  input wire pwr_seq_pkg::wake_events_t wake_events,
  input wire logic sleep_instr,
  input wire logic watchdog_kick_instr,
  input wire logic irq_global_en,
  input wire logic timer_zero_enable,
  input wire logic timer_one_enable,
  input wire logic timer_three_enable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output pwr_seq_pkg::clock_ctrl_t clock_ctrl,
  output logic [2:0] timer_run,
  output logic watchdog_clear,
  output logic core_reset,
  output logic resume_pulse,
  output logic resume_to_vector,
  output logic [11:0] resume_vector
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pwr_seq_pkg::seq_state_t state_reg, state_next;
  logic [7:0] osc_control_reg, config_reg;
  logic timeout_flag_reg, power_down_flag_reg, halt_settle_reg, irq_at_sleep_reg;
  logic ext_reset_n_sync, ext_reset_n_prev_reg, pin_reset_fall, any_reset, in_halt;
  logic bus_req, bus_write, ctrl_write, high_osc_select, high_osc_stop;
  logic [1:0] mode_wr;
  logic [2:0] pwrup_sel;
  logic standby_wake, halt_wake, us_tick, osc_tick;
  logic [26:0] us_tick_cnt_reg, pwrup_value;
  logic [12:0] osc_cnt_reg;
  logic pwrup_load, pwrup_done, settle_load, settle_done;
  logic [9:0] settle_value;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  function automatic logic [26:0] pwrup_us(input logic [2:0] sel);
    case (sel)
      3'h0: pwrup_us = 27'(pwr_seq_pkg::pwrup_us_0);
      3'h1: pwrup_us = 27'(pwr_seq_pkg::pwrup_us_1);
      3'h2: pwrup_us = 27'(pwr_seq_pkg::pwrup_us_2);
      3'h3: pwrup_us = 27'(pwr_seq_pkg::pwrup_us_3);
      default: pwrup_us = 27'(pwr_seq_pkg::pwrup_us_4);
    endcase
  endfunction
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    is_addr = (a == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin and reset sources
  pin_sync u_reset_pin (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(ext_reset_n),
    .pin_out(ext_reset_n_sync)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_reset_n_prev_reg <= 1'b1;
    end else begin
      ext_reset_n_prev_reg <= ext_reset_n_sync;
    end
  end

  assign pin_reset_fall = ext_reset_n_prev_reg && !ext_reset_n_sync;
  assign any_reset = reset_events.power_on || reset_events.low_voltage_reset
                     || reset_events.watchdog_reset || !ext_reset_n_sync;
  assign in_halt = (state_reg == pwr_seq_pkg::st_halt);

  ////////////////////////////////////////////////////////////////////////////
  // Time bases
  // One pulse per microsecond for the power-up delay
  always_ff @(posedge ref_clk) begin
    if (sys_rst || us_tick) begin
      us_tick_cnt_reg <= '0;
    end else begin
      us_tick_cnt_reg <= us_tick_cnt_reg + 27'h1;
    end
  end
  assign us_tick = (us_tick_cnt_reg == 27'(us_div - 1));

  // Pulse per system oscillator cycle; restarted on each halt wake and at the end of power-up
  always_ff @(posedge ref_clk) begin
    if (sys_rst || osc_tick || settle_load) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 13'h1;
    end
  end
  assign osc_tick = high_osc_select ? (osc_cnt_reg == 13'(fast_div - 1))
                                    : (osc_cnt_reg == 13'(slow_div - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign bus_write = bus_req && wb_we_i && wb_sel_i[0];
  assign ctrl_write = bus_write && is_addr(wb_adr_i, pwr_seq_pkg::addr_osc_control);
  assign mode_wr = wb_dat_i[pwr_seq_pkg::power_mode_hi:pwr_seq_pkg::power_mode_lo];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && (is_addr(wb_adr_i, pwr_seq_pkg::addr_osc_control)
                  || is_addr(wb_adr_i, pwr_seq_pkg::addr_status)
                  || is_addr(wb_adr_i, pwr_seq_pkg::addr_config)
                  || is_addr(wb_adr_i, pwr_seq_pkg::addr_mode));
      wb_err_o <= bus_req && !(is_addr(wb_adr_i, pwr_seq_pkg::addr_osc_control)
                  || is_addr(wb_adr_i, pwr_seq_pkg::addr_status)
                  || is_addr(wb_adr_i, pwr_seq_pkg::addr_config)
                  || is_addr(wb_adr_i, pwr_seq_pkg::addr_mode));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_dat_o <= '0;
    end else if (bus_req) begin
      case (wb_adr_i)
        pwr_seq_pkg::addr_osc_control: wb_dat_o <= {24'h0, osc_control_reg};
        pwr_seq_pkg::addr_status: wb_dat_o <= {27'h0, timeout_flag_reg,
                                              power_down_flag_reg, 3'h0};
        pwr_seq_pkg::addr_config: wb_dat_o <= {24'h0, config_reg};
        pwr_seq_pkg::addr_mode: wb_dat_o <= {25'h0, state_reg == pwr_seq_pkg::st_pwrup,
                                            halt_settle_reg, in_halt,
                                            state_reg == pwr_seq_pkg::st_standby,
                                            state_reg == pwr_seq_pkg::st_run
                                              && !high_osc_select,
                                            state_reg == pwr_seq_pkg::st_run
                                              && high_osc_select,
                                            state_reg == pwr_seq_pkg::st_reset};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers
  // Mode field is a command; it always reads back as zero once acted on
  always_ff @(posedge ref_clk) begin
    if (sys_rst || any_reset) begin
      osc_control_reg <= pwr_seq_pkg::osc_control_reset;
      osc_control_reg[pwr_seq_pkg::high_osc_select_bit] <=
        config_reg[pwr_seq_pkg::startup_fast_bit];
    end else if (ctrl_write && state_reg == pwr_seq_pkg::st_run) begin
      osc_control_reg <= wb_dat_i[7:0];
      osc_control_reg[pwr_seq_pkg::power_mode_hi:pwr_seq_pkg::power_mode_lo] <=
        pwr_seq_pkg::pm_run;
    end
  end

  // Configuration survives device resets, only the system reset loads it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      config_reg <= pwr_seq_pkg::config_reset;
    end else if (bus_write && is_addr(wb_adr_i, pwr_seq_pkg::addr_config)) begin
      config_reg <= wb_dat_i[7:0];
    end
  end

  assign high_osc_select = osc_control_reg[pwr_seq_pkg::high_osc_select_bit];
  assign high_osc_stop = osc_control_reg[pwr_seq_pkg::high_osc_stop_bit];
  assign pwrup_sel = config_reg[pwr_seq_pkg::pwrup_sel_hi:pwr_seq_pkg::pwrup_sel_lo];

  ////////////////////////////////////////////////////////////////////////////
  // Timeout and power-down flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst || reset_events.power_on || reset_events.low_voltage_reset) begin
      timeout_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b1;
    end else if (reset_events.watchdog_reset && state_reg != pwr_seq_pkg::st_reset) begin
      timeout_flag_reg <= 1'b0;
      power_down_flag_reg <= !in_halt;
    end else if (pin_reset_fall && in_halt) begin
      timeout_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b1;
    end else if (state_next == pwr_seq_pkg::st_halt && state_reg == pwr_seq_pkg::st_run) begin
      timeout_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b0;
    end else if (watchdog_kick_instr && state_reg == pwr_seq_pkg::st_run) begin
      timeout_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign standby_wake = |wake_events;
  assign halt_wake = wake_events.watchdog_timeout || wake_events.port_change
                     || wake_events.ext_irq_zero || wake_events.ext_irq_one;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pwr_seq_pkg::st_reset: begin
        if (!any_reset) begin
          state_next = pwr_seq_pkg::st_pwrup;
        end
      end
      pwr_seq_pkg::st_pwrup: begin
        if (pwrup_done) begin
          state_next = pwr_seq_pkg::st_ost;
        end
      end
      pwr_seq_pkg::st_ost: begin
        if (settle_done) begin
          state_next = pwr_seq_pkg::st_run;
        end
      end
      pwr_seq_pkg::st_run: begin
        if (sleep_instr || (ctrl_write && mode_wr == pwr_seq_pkg::pm_halt)) begin
          state_next = pwr_seq_pkg::st_halt;
        end else if (ctrl_write && mode_wr == pwr_seq_pkg::pm_standby) begin
          state_next = pwr_seq_pkg::st_standby;
        end
      end
      pwr_seq_pkg::st_standby: begin
        if (standby_wake) begin
          state_next = pwr_seq_pkg::st_run;
        end
      end
      pwr_seq_pkg::st_halt: begin
        if (halt_settle_reg && settle_done) begin
          state_next = pwr_seq_pkg::st_run;
        end
      end
      default: state_next = pwr_seq_pkg::st_reset;
    endcase
    if (any_reset) begin
      state_next = pwr_seq_pkg::st_reset;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= pwr_seq_pkg::st_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  // Halt stays put while the settle count runs, so a second wake restarts it
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_reg != pwr_seq_pkg::st_halt) begin
      halt_settle_reg <= 1'b0;
    end else if (halt_wake) begin
      halt_settle_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_at_sleep_reg <= 1'b0;
    end else if (state_reg == pwr_seq_pkg::st_run) begin
      irq_at_sleep_reg <= irq_global_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay timers
  assign pwrup_load = (state_reg == pwr_seq_pkg::st_reset) && !any_reset;
  assign pwrup_value = pwrup_us(pwrup_sel);

  cycle_timer #(.width(27)) u_pwrup_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(pwrup_load),
    .load_value(pwrup_value),
    .tick(us_tick),
    .done(pwrup_done)
  );

  assign settle_load = (state_reg == pwr_seq_pkg::st_pwrup && pwrup_done)
                       || (in_halt && halt_wake);
  assign settle_value = (state_reg == pwr_seq_pkg::st_pwrup)
    ? ((pwrup_sel == 3'h0) ? pwr_seq_pkg::ost_short : pwr_seq_pkg::ost_long)
    : (config_reg[pwr_seq_pkg::crystal_mode_bit] ? pwr_seq_pkg::halt_settle_xtal
                                                 : pwr_seq_pkg::halt_settle_rc);

  cycle_timer #(.width(10)) u_settle_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(settle_load),
    .load_value(settle_value),
    .tick(osc_tick),
    .done(settle_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clock_ctrl <= '0;
      timer_run <= '0;
      watchdog_clear <= 1'b0;
      core_reset <= 1'b1;
      resume_pulse <= 1'b0;
      resume_to_vector <= 1'b0;
    end else begin
      clock_ctrl.fast_osc_en <= !high_osc_stop && !(in_halt && !halt_settle_reg);
      clock_ctrl.slow_osc_en <= !(in_halt && !halt_settle_reg);
      clock_ctrl.sys_clk_fast <= high_osc_select;
      clock_ctrl.cpu_run <= (state_next == pwr_seq_pkg::st_run);
      clock_ctrl.periph_en <= (state_reg == pwr_seq_pkg::st_run);
      clock_ctrl.timers_en <= !in_halt && state_reg != pwr_seq_pkg::st_reset;
      clock_ctrl.timer_zero_slow_clk <= high_osc_select
        && osc_control_reg[pwr_seq_pkg::low_clk_to_timer_zero_bit]
        && config_reg[pwr_seq_pkg::timer_zero_src_bit];
      timer_run <= (in_halt || state_reg == pwr_seq_pkg::st_reset) ? 3'h0
                   : {timer_three_enable, timer_one_enable, timer_zero_enable};
      watchdog_clear <= (state_next == pwr_seq_pkg::st_halt)
                        && (state_reg == pwr_seq_pkg::st_run);
      core_reset <= (state_next != pwr_seq_pkg::st_run) && (state_reg != pwr_seq_pkg::st_run
                    || state_next == pwr_seq_pkg::st_reset);
      resume_pulse <= (state_next == pwr_seq_pkg::st_run)
                      && (in_halt || state_reg == pwr_seq_pkg::st_standby);
      resume_to_vector <= irq_at_sleep_reg;
    end
  end

  assign resume_vector = pwr_seq_pkg::irq_vector;

endmodule

// file: dv/pmrs_assertions.sv
// Port-level checks for the mode and reset sequencer
`timescale 1ns/10ps
module pmrs_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_reset_n,
  input wire pwr_seq_pkg::reset_events_t reset_events,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire pwr_seq_pkg::clock_ctrl_t clock_ctrl,
  input wire logic [2:0] timer_run,
  input wire logic watchdog_clear,
  input wire logic core_reset,
  input wire logic resume_pulse,
  input wire logic [11:0] resume_vector
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  AST_BUS_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("bus request not answered");
  AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_RUN_SLOW_OSC: assert property (
    clock_ctrl.cpu_run |-> clock_ctrl.slow_osc_en) else $error("slow osc off in run");
  AST_FAST_CLK_ON: assert property (
    clock_ctrl.cpu_run && clock_ctrl.sys_clk_fast |-> clock_ctrl.fast_osc_en)
    else $error("fast clock selected but stopped");
  AST_HALT_GATES: assert property (watchdog_clear |-> ##[0:2] (
    !clock_ctrl.fast_osc_en && !clock_ctrl.slow_osc_en && !clock_ctrl.periph_en
    && timer_run == 3'h0)) else $error("halt left clocks running");
  AST_SLOW_OFF_IDLE: assert property (!clock_ctrl.slow_osc_en |->
    timer_run == 3'h0 && !clock_ctrl.cpu_run) else $error("timers run without osc");
  AST_RESET_HOLD: assert property (core_reset |-> !clock_ctrl.cpu_run)
    else $error("run during reset");
  AST_POR_ENTER: assert property (reset_events.power_on |-> ##[1:3] core_reset)
    else $error("power-on reset missed");
  AST_PIN_ENTER: assert property (!ext_reset_n |-> ##[1:6] core_reset)
    else $error("pin reset missed");
  AST_WDT_CLEAR_PULSE: assert property (watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear too long");
  AST_RESUME_RUN: assert property (resume_pulse |-> ##[0:1] clock_ctrl.cpu_run)
    else $error("resume without run");
  AST_VECTOR: assert property (resume_pulse |-> resume_vector == 12'h008)
    else $error("wrong resume vector");
endmodule

// file: dv/test_power_mode_reset_sequencer.sv
// Directed bench for the mode and reset sequencer
`timescale 1ns/10ps
module test_power_mode_reset_sequencer;
  logic ref_clk, sys_rst = 1, ext_reset_n = 1, sleep_instr = 0, watchdog_kick_instr = 0;
  logic irq_global_en = 1, timer_zero_enable = 1, timer_one_enable = 0;
  logic timer_three_enable = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, wb_err_o, watchdog_clear, core_reset, resume_pulse, resume_to_vector;
  logic [2:0] timer_run;
  logic [11:0] resume_vector;
  pwr_seq_pkg::reset_events_t reset_events = '0;
  pwr_seq_pkg::wake_events_t wake_events = '0;
  pwr_seq_pkg::clock_ctrl_t clock_ctrl;
  int fails = 0, num_checks = 0;
  // Short microsecond and slow divides keep power-up to under 150 cycles
  power_mode_reset_sequencer #(.us_div(1), .slow_div(3)) power_mode_reset_sequencer_i (
    .ref_clk, .sys_rst, .ext_reset_n, .reset_events, .wake_events, .sleep_instr,
    .watchdog_kick_instr, .irq_global_en, .timer_zero_enable, .timer_one_enable,
    .timer_three_enable, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .clock_ctrl, .timer_run, .watchdog_clear,
    .core_reset, .resume_pulse, .resume_to_vector, .resume_vector);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Request held until ack or err is sampled at a rising edge, released at that edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      fails++;
      conclude();
    end
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0, q, e);
    chk(what, q, exp);
  endtask
  task automatic wait_mode(input logic [31:0] exp);
    int n;
    logic [31:0] q;
    logic e;
    n = 0;
    do begin
      bus(1'b0, pwr_seq_pkg::addr_mode, 32'h0, q, e);
      n++;
    end while (q !== exp && n < 400);
    chk("mode wait", q, exp);
    if (q !== exp) begin
      conclude();
    end
  endtask
  task automatic wake(input logic [8:0] w);
    @(posedge ref_clk);
    wake_events <= w;
    @(posedge ref_clk);
    wake_events <= '0;
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    logic [31:0] q;
    logic e;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Shortest power-up, fast startup, timer zero slow source
    wr(pwr_seq_pkg::addr_config, 32'h28);
    @(posedge ref_clk);
    reset_events <= 3'h4;
    @(posedge ref_clk);
    reset_events <= 3'h0;
    wait_mode(32'h02);
    rd(pwr_seq_pkg::addr_status, 32'h18, "status after power-on");
    chk("timer run", timer_run, 3'h1);
    wr(pwr_seq_pkg::addr_osc_control, 32'h11);
    @(negedge ref_clk);
    chk("slow clock to timer zero", clock_ctrl.timer_zero_slow_clk, 1'b1);
    wr(pwr_seq_pkg::addr_osc_control, 32'h00);
    rd(pwr_seq_pkg::addr_mode, 32'h04, "slow mode");
    chk("fast osc kept", clock_ctrl.fast_osc_en, 1'b1);
    wr(pwr_seq_pkg::addr_osc_control, 32'h02);
    @(negedge ref_clk);
    chk("fast osc stopped", clock_ctrl.fast_osc_en, 1'b0);
    wr(pwr_seq_pkg::addr_osc_control, 32'h0a);
    rd(pwr_seq_pkg::addr_mode, 32'h08, "standby");
    chk("standby cpu", clock_ctrl.cpu_run, 1'b0);
    wake(9'h001);
    rd(pwr_seq_pkg::addr_mode, 32'h04, "standby wake");
    // Stop bit and halt entry in one write
    wr(pwr_seq_pkg::addr_osc_control, 32'h06);
    rd(pwr_seq_pkg::addr_status, 32'h10, "status in halt");
    chk("halt oscs", {clock_ctrl.fast_osc_en, clock_ctrl.slow_osc_en}, 2'h0);
    chk("halt timers", clock_ctrl.timers_en, 1'b0);
    wake(9'h100);
    rd(pwr_seq_pkg::addr_mode, 32'h10, "halt ignores timer");
    wake(9'h010);
    rd(pwr_seq_pkg::addr_mode, 32'h30, "halt settling");
    wait_mode(32'h04);
    chk("vector on resume", resume_to_vector, 1'b1);
    irq_global_en <= 1'b0;
    @(posedge ref_clk);
    sleep_instr <= 1'b1;
    @(posedge ref_clk);
    sleep_instr <= 1'b0;
    rd(pwr_seq_pkg::addr_mode, 32'h10, "sleep halt");
    chk("no vector when disabled", resume_to_vector, 1'b0);
    @(posedge ref_clk);
    reset_events <= 3'h1;
    @(posedge ref_clk);
    reset_events <= 3'h0;
    wait_mode(32'h02);
    rd(pwr_seq_pkg::addr_status, 32'h00, "status watchdog in halt");
    rd(pwr_seq_pkg::addr_osc_control, 32'h01, "control reloaded");
    @(posedge ref_clk);
    ext_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    ext_reset_n <= 1'b1;
    wait_mode(32'h02);
    rd(pwr_seq_pkg::addr_status, 32'h00, "status pin reset");
    bus(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped error", e, 1'b1);
    conclude();
  end
endmodule

bind power_mode_reset_sequencer pmrs_assertions pmrs_assertions_i (.ref_clk, .sys_rst,
  .ext_reset_n, .reset_events, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .clock_ctrl,
  .timer_run, .watchdog_clear, .core_reset, .resume_pulse, .resume_vector);
